// file: design/mrscr_pkg.sv
// Contract
// - Peak registers take the largest-magnitude signed sample of each low-rate interval.
// - Apparent power is RMS voltage times RMS current, non-negative fraction.
// - Power factor is active over apparent power, signed like active power.
// - Temperature is 24-bit two's complement, binary point after bit 16.
// - Pulse source registers hold signed values feeding the energy pulse outputs.
// - Writing one clears a status bit above bit 0 only once its cause is gone; writing one to bit 0 sets it.
// - A mask bit of one lets its status bit drive the interrupt pin.
// - Bit 23 sets on low-rate update, command completion and reset completion.
// - Bit 20 sets whenever sample-rate results are refreshed.
// - Instantaneous overrange flags at bits 17, 22, 16 and 21.
// - RMS overrange flags at bits 14, 19, 13 and 18.
// - Energy overrange flags at bits 12 and 15.
// - Current fault flags at bits 11 and 9, sag flags at 10 and 8.
// - Bit 7 sets on temperature update, bit 1 on line-frequency update.
// - Oscillation flags at bits 4, 6, 3 and 5.
// - Bit 2 sets on low supply and resists clearing until supply is high.
// - Bit 0 normally reads one and drops to zero on an invalid command.
// - Control bits 23 to 16 hold the signed channel-2 phase delay.
// - Range select bits 5 and 12: zero 250 mV, one 50 mV.
// - Writing one to control bit 8 stops a serial-memory sequence.
// - Control bit 4 makes the interrupt output open-drain.
// - Control bit 2 disables the clock output, bit 1 the crystal oscillator.
// - Interrupt pin: level low, level high, low pulse or high pulse.
package mrscr_pkg;
   localparam int W = 24;
   localparam logic [4:0] ADDR_STATUS    = 5'h0F;
   localparam logic [4:0] ADDR_I1_PEAK   = 5'h12;
   localparam logic [4:0] ADDR_V1_PEAK   = 5'h13;
   localparam logic [4:0] ADDR_S1        = 5'h14;
   localparam logic [4:0] ADDR_PF1       = 5'h15;
   localparam logic [4:0] ADDR_I2_PEAK   = 5'h16;
   localparam logic [4:0] ADDR_V2_PEAK   = 5'h17;
   localparam logic [4:0] ADDR_S2        = 5'h18;
   localparam logic [4:0] ADDR_PF2       = 5'h19;
   localparam logic [4:0] ADDR_MASK      = 5'h1A;
   localparam logic [4:0] ADDR_TEMP      = 5'h1B;
   localparam logic [4:0] ADDR_CTRL      = 5'h1C;
   localparam logic [4:0] ADDR_ACT_PULSE = 5'h1D;
   localparam logic [4:0] ADDR_APP_PULSE = 5'h1E;
   localparam logic [4:0] ADDR_REA_PULSE = 5'h1F;
   localparam logic [23:0] STATUS_RESET  = 24'h000001;
   localparam logic [23:0] MASK_RESET    = 24'h000000;
   localparam logic [23:0] CTRL_RESET    = 24'h000000;
   localparam logic [23:0] CTRL_STORE    = 24'hFF1036;
   localparam logic [23:0] COND_BITS     = 24'h6FFF78;
   localparam int BIT_LOWRATE_RDY = 23;
   localparam int BIT_SAMPLE_RDY  = 20;
   localparam int BIT_TEMP_UPD    = 7;
   localparam int BIT_LOW_SUPPLY  = 2;
   localparam int BIT_FREQ_UPD    = 1;
   localparam int BIT_BAD_CMD     = 0;
   localparam int CTRL_PHASE_LSB  = 16;
   localparam int CTRL_CUR2_RANGE = 12;
   localparam int CTRL_MEM_STOP   = 8;
   localparam int CTRL_CUR1_RANGE = 5;
   localparam int CTRL_IRQ_OD     = 4;
   localparam int CTRL_NO_CLKOUT  = 2;
   localparam int CTRL_NO_OSC     = 1;
   localparam int S_SHIFT         = 25;
   localparam logic [4:0] DIV_STEPS = 5'h17;
   localparam logic [23:0] PF_POS_MAX = 24'h7FFFFF;
   localparam logic [23:0] PF_NEG_MAX = 24'h800000;
   typedef enum logic [1:0] {
      MRSCR_IDLE = 2'b00,
      MRSCR_CH1  = 2'b01,
      MRSCR_CH2  = 2'b10
   } mrscr_div_e;
   typedef struct packed {
      logic [23:0] cur1;
      logic [23:0] volt1;
      logic [23:0] cur2;
      logic [23:0] volt2;
   } mrscr_quad_s;
   typedef struct packed {
      logic [23:0] active;
      logic [23:0] apparent;
      logic [23:0] reactive;
   } mrscr_pulse_s;
endpackage

// file: design/mrscr_regs.sv
`timescale 1ns/1ps
`default_nettype none
module mrscr_regs (
   input  wire logic                 CLK_SYS,
   input  wire logic                 RST_N,
   input  wire logic                 REG_SEL,
   input  wire logic [4:0]           REG_ADDR,
   input  wire logic                 REG_WR,
   input  wire logic                 REG_RD,
   input  wire logic [23:0]          REG_WDATA,
   output logic [23:0]               REG_RDATA,
   input  wire logic                 SAMPLE_STB,
   input  wire logic                 LOWRATE_STB,
   input  wire mrscr_pkg::mrscr_quad_s SAMPLES,
   input  wire mrscr_pkg::mrscr_quad_s RMS,
   input  wire logic [23:0]          P1_AVG,
   input  wire logic [23:0]          P2_AVG,
   input  wire mrscr_pkg::mrscr_pulse_s PULSE_IN,
   input  wire logic                 TEMP_STB,
   input  wire logic [23:0]          TEMP_IN,
   input  wire logic                 FREQ_STB,
   input  wire logic                 CMD_DONE,
   input  wire logic                 BAD_CMD,
   input  wire logic [23:0]          STATUS_COND,
   input  wire logic                 SUPPLY_BELOW_LOW,
   input  wire logic                 SUPPLY_ABOVE_HIGH,
   input  wire logic                 IRQ_PULSE_SELECT,
   input  wire logic                 IRQ_POLARITY_SELECT,
   output mrscr_pkg::mrscr_pulse_s   PULSE_SRC,
   output logic [7:0]                PHASE_DELAY_CH2,
   output logic                      CUR1_RANGE_SELECT,
   output logic                      CUR2_RANGE_SELECT,
   output logic                      SERIAL_MEM_STOP,
   output logic                      HOST_CLOCK_OUT_DISABLE,
   output logic                      CRYSTAL_OSC_DISABLE,
   output logic                      IRQ_OUT,
   output logic                      IRQ_OE
);
   import mrscr_pkg::*;

   // ==========================================================
   // Helper functions.
   function automatic logic [23:0] mag(input logic [23:0] x);
      mag = x[23] ? 24'(~x + 24'h000001) : x;
   endfunction

   function automatic logic [23:0] apparent(input logic [23:0] vr,
                                            input logic [23:0] ir);
      logic [47:0] prod;
      prod = {24'h000000, vr} * {24'h000000, ir};
      apparent = {1'b0, prod[47:S_SHIFT]};
   endfunction

   // ==========================================================
   // State.
   logic [23:0] status_reg;
   logic [23:0] mask_reg;
   logic [23:0] ctrl_reg;
   logic        stop_reg;
   logic        boot_reg;
   logic        low_supply_hold_reg;
   mrscr_quad_s run_reg;
   mrscr_quad_s peak_reg;
   logic [23:0] s1_reg;
   logic [23:0] s2_reg;
   logic [23:0] pf1_reg;
   logic [23:0] pf2_reg;
   logic [23:0] p2_hold_reg;
   logic [23:0] temp_reg;
   mrscr_pulse_s pulse_reg;
   logic [23:0] rdata_reg;
   logic        irq_req_reg;
   logic        irq_out_reg;
   logic        irq_oe_reg;
   mrscr_div_e  div_state_reg;
   mrscr_div_e  div_state_next;
   logic [4:0]  div_cnt_reg;
   logic [24:0] div_rem_reg;
   logic [22:0] div_quo_reg;
   logic        div_neg_reg;
   logic        div_sat_reg;

   // ==========================================================
   // Bus decode.
   wire wr_status = REG_SEL & REG_WR & (REG_ADDR == ADDR_STATUS);
   wire wr_mask   = REG_SEL & REG_WR & (REG_ADDR == ADDR_MASK);
   wire wr_ctrl   = REG_SEL & REG_WR & (REG_ADDR == ADDR_CTRL);
   wire rd_any    = REG_SEL & REG_RD;

   // ==========================================================
   // Peak tracking.
   function automatic logic [23:0] bigger(input logic [23:0] a,
                                          input logic [23:0] b);
      bigger = (mag(b) > mag(a)) ? b : a;
   endfunction

   mrscr_quad_s run_now;
   assign run_now.cur1  = SAMPLE_STB ? bigger(run_reg.cur1, SAMPLES.cur1)
                                     : run_reg.cur1;
   assign run_now.volt1 = SAMPLE_STB ? bigger(run_reg.volt1, SAMPLES.volt1)
                                     : run_reg.volt1;
   assign run_now.cur2  = SAMPLE_STB ? bigger(run_reg.cur2, SAMPLES.cur2)
                                     : run_reg.cur2;
   assign run_now.volt2 = SAMPLE_STB ? bigger(run_reg.volt2, SAMPLES.volt2)
                                     : run_reg.volt2;

   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         run_reg  <= '0;
         peak_reg <= '0;
      end else if (LOWRATE_STB) begin
         peak_reg <= run_now;
         run_reg  <= '0;
      end else begin
         run_reg  <= run_now;
      end
   end

   // ==========================================================
   // Apparent power, pulse sources and temperature.
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         s1_reg      <= '0;
         s2_reg      <= '0;
         p2_hold_reg <= '0;
         pulse_reg   <= '0;
      end else if (LOWRATE_STB) begin
         s1_reg      <= apparent(RMS.volt1, RMS.cur1);
         s2_reg      <= apparent(RMS.volt2, RMS.cur2);
         p2_hold_reg <= P2_AVG;
         pulse_reg   <= PULSE_IN;
      end
   end

   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         temp_reg <= '0;
      end else if (TEMP_STB) begin
         temp_reg <= TEMP_IN;
      end
   end

   // ==========================================================
   // Power factor divider, channel 1 then channel 2.
   wire        div_ch2   = (div_state_reg == MRSCR_CH2);
   wire [23:0] div_den   = div_ch2 ? s2_reg : s1_reg;
   wire [24:0] div_shift = {div_rem_reg[23:0], 1'b0};
   wire        div_ge    = div_shift >= {1'b0, div_den};
   wire [24:0] div_rem_n = div_ge ? 25'(div_shift - {1'b0, div_den})
                                  : div_shift;
   wire [22:0] div_quo_n = {div_quo_reg[21:0], div_ge};
   wire        div_last  = (div_cnt_reg == DIV_STEPS);
   wire [23:0] pf_mag    = {1'b0, div_quo_reg};
   wire [23:0] pf_val    = div_sat_reg ?
                           (div_neg_reg ? PF_NEG_MAX : PF_POS_MAX) :
                           (div_neg_reg ? 24'(~pf_mag + 24'h000001)
                                        : pf_mag);
   wire [23:0] p2_mag    = mag(p2_hold_reg);
   wire        p2_sat    = (p2_mag >= s2_reg);

   always_comb begin
      div_state_next = div_state_reg;
      case (div_state_reg)
         MRSCR_IDLE: begin
            if (LOWRATE_STB) begin
               div_state_next = MRSCR_CH1;
            end
         end
         MRSCR_CH1: begin
            if (div_last) begin
               div_state_next = MRSCR_CH2;
            end
         end
         MRSCR_CH2: begin
            if (div_last) begin
               div_state_next = MRSCR_IDLE;
            end
         end
         default: begin
            div_state_next = MRSCR_IDLE;
         end
      endcase
   end

   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         div_state_reg <= MRSCR_IDLE;
         div_cnt_reg   <= '0;
         div_rem_reg   <= '0;
         div_quo_reg   <= '0;
         div_neg_reg   <= 1'b0;
         div_sat_reg   <= 1'b0;
         pf1_reg       <= '0;
         pf2_reg       <= '0;
      end else begin
         div_state_reg <= div_state_next;
         if (div_state_reg == MRSCR_IDLE) begin
            div_cnt_reg <= '0;
            div_quo_reg <= '0;
            div_rem_reg <= {1'b0, mag(P1_AVG)};
            div_neg_reg <= P1_AVG[23];
            div_sat_reg <= (mag(P1_AVG) >= apparent(RMS.volt1, RMS.cur1));
         end else if (!div_last) begin
            div_cnt_reg <= div_cnt_reg + 5'h01;
            div_rem_reg <= div_rem_n;
            div_quo_reg <= div_quo_n;
         end else begin
            if (div_ch2) begin
               pf2_reg <= pf_val;
            end else begin
               pf1_reg <= pf_val;
            end
            div_cnt_reg <= '0;
            div_quo_reg <= '0;
            div_rem_reg <= {1'b0, p2_mag};
            div_neg_reg <= p2_hold_reg[23];
            div_sat_reg <= p2_sat;
         end
      end
   end

   // ==========================================================
   // Status register.
   wire [23:0] cond_level = STATUS_COND & COND_BITS;
   wire [23:0] set_vec =
      cond_level |
      (24'((LOWRATE_STB | CMD_DONE | boot_reg)) << BIT_LOWRATE_RDY) |
      (24'(SAMPLE_STB) << BIT_SAMPLE_RDY) |
      (24'(TEMP_STB) << BIT_TEMP_UPD) |
      (24'(FREQ_STB) << BIT_FREQ_UPD) |
      (24'(low_supply_hold_reg) << BIT_LOW_SUPPLY);
   wire [23:0] w1c_vec   = wr_status ? REG_WDATA : 24'h000000;
   wire [23:0] clr_vec   = w1c_vec & ~set_vec;
   wire [23:0] st_upper  = (status_reg & ~clr_vec) | set_vec;
   wire        bad_next  = BAD_CMD ? 1'b0 :
                           (w1c_vec[BIT_BAD_CMD] | status_reg[BIT_BAD_CMD]);
   wire [23:0] status_next = {st_upper[23:1], bad_next};

   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         status_reg <= STATUS_RESET;
         boot_reg   <= 1'b1;
      end else begin
         status_reg <= status_next;
         boot_reg   <= 1'b0;
      end
   end

   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         low_supply_hold_reg <= 1'b0;
      end else if (SUPPLY_BELOW_LOW) begin
         low_supply_hold_reg <= 1'b1;
      end else if (SUPPLY_ABOVE_HIGH) begin
         low_supply_hold_reg <= 1'b0;
      end
   end

   // ==========================================================
   // Mask and control registers.
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         mask_reg <= MASK_RESET;
         ctrl_reg <= CTRL_RESET;
         stop_reg <= 1'b0;
      end else begin
         if (wr_mask) begin
            mask_reg <= REG_WDATA;
         end
         if (wr_ctrl) begin
            ctrl_reg <= REG_WDATA & CTRL_STORE;
         end
         stop_reg <= wr_ctrl & REG_WDATA[CTRL_MEM_STOP];
      end
   end

   // ==========================================================
   // Interrupt pin.
   wire irq_req_next = |(status_next & mask_reg);
   wire irq_active   = IRQ_PULSE_SELECT ? (irq_req_next & ~irq_req_reg)
                                        : irq_req_next;
   wire irq_level    = IRQ_POLARITY_SELECT ? irq_active : ~irq_active;
   wire od_next      = wr_ctrl ? REG_WDATA[CTRL_IRQ_OD]
                               : ctrl_reg[CTRL_IRQ_OD];
   wire irq_oe_next  = ~od_next | ~irq_level;

   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         irq_req_reg <= 1'b0;
         irq_out_reg <= 1'b1;
         irq_oe_reg  <= 1'b1;
      end else begin
         irq_req_reg <= irq_req_next;
         irq_out_reg <= irq_level;
         irq_oe_reg  <= irq_oe_next;
      end
   end

   // ==========================================================
   // Read data.
   logic [23:0] rmux;
   always_comb begin
      case (REG_ADDR)
         ADDR_STATUS:    rmux = status_reg;
         ADDR_I1_PEAK:   rmux = peak_reg.cur1;
         ADDR_V1_PEAK:   rmux = peak_reg.volt1;
         ADDR_S1:        rmux = s1_reg;
         ADDR_PF1:       rmux = pf1_reg;
         ADDR_I2_PEAK:   rmux = peak_reg.cur2;
         ADDR_V2_PEAK:   rmux = peak_reg.volt2;
         ADDR_S2:        rmux = s2_reg;
         ADDR_PF2:       rmux = pf2_reg;
         ADDR_MASK:      rmux = mask_reg;
         ADDR_TEMP:      rmux = temp_reg;
         ADDR_CTRL:      rmux = ctrl_reg;
         ADDR_ACT_PULSE: rmux = pulse_reg.active;
         ADDR_APP_PULSE: rmux = pulse_reg.apparent;
         ADDR_REA_PULSE: rmux = pulse_reg.reactive;
         default:        rmux = 24'h000000;
      endcase
   end

   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         rdata_reg <= '0;
      end else if (rd_any) begin
         rdata_reg <= rmux;
      end
   end

   // ==========================================================
   // Outputs.
   assign REG_RDATA              = rdata_reg;
   assign PULSE_SRC              = pulse_reg;
   assign PHASE_DELAY_CH2        = ctrl_reg[CTRL_PHASE_LSB +: 8];
   assign CUR1_RANGE_SELECT      = ctrl_reg[CTRL_CUR1_RANGE];
   assign CUR2_RANGE_SELECT      = ctrl_reg[CTRL_CUR2_RANGE];
   assign SERIAL_MEM_STOP        = stop_reg;
   assign HOST_CLOCK_OUT_DISABLE = ctrl_reg[CTRL_NO_CLKOUT];
   assign CRYSTAL_OSC_DISABLE    = ctrl_reg[CTRL_NO_OSC];
   assign IRQ_OUT                = irq_out_reg;
   assign IRQ_OE                 = irq_oe_reg;
endmodule
`default_nettype wire

// file: testbench/mrscr_regs_checker.sv
`timescale 1ns/1ps
`default_nettype none
module mrscr_regs_checker (
   input wire logic                    CLK_SYS,
   input wire logic                    RST_N,
   input wire logic                    REG_SEL,
   input wire logic [4:0]              REG_ADDR,
   input wire logic                    REG_WR,
   input wire logic [23:0]             REG_WDATA,
   input wire logic                    LOWRATE_STB,
   input wire mrscr_pkg::mrscr_pulse_s PULSE_IN,
   input wire logic                    IRQ_PULSE_SELECT,
   input wire logic                    IRQ_POLARITY_SELECT,
   input wire mrscr_pkg::mrscr_pulse_s PULSE_SRC,
   input wire logic [7:0]              PHASE_DELAY_CH2,
   input wire logic                    CUR1_RANGE_SELECT,
   input wire logic                    CUR2_RANGE_SELECT,
   input wire logic                    SERIAL_MEM_STOP,
   input wire logic                    HOST_CLOCK_OUT_DISABLE,
   input wire logic                    CRYSTAL_OSC_DISABLE,
   input wire logic                    IRQ_OUT,
   input wire logic                    IRQ_OE
);
   import mrscr_pkg::*;
   // ====================
   // Shadow copies of the written control and mask words.
   logic [23:0] ctl_reg, ctl_next, msk_reg, msk_next;
   wire         ctl_wr  = REG_SEL && REG_WR && (REG_ADDR == ADDR_CTRL);
   wire         msk_wr  = REG_SEL && REG_WR && (REG_ADDR == ADDR_MASK);
   wire         stop_rq = ctl_wr && REG_WDATA[CTRL_MEM_STOP];
   wire         od_w    = ctl_reg[CTRL_IRQ_OD];
   wire         hi_puls = IRQ_PULSE_SELECT && IRQ_POLARITY_SELECT;
   assign ctl_next = ctl_wr ? REG_WDATA : ctl_reg;
   assign msk_next = msk_wr ? REG_WDATA : msk_reg;
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         ctl_reg <= CTRL_RESET;
         msk_reg <= MASK_RESET;
      end else begin
         ctl_reg <= ctl_next;
         msk_reg <= msk_next;
      end
   end
   // ====================
   // Properties.
   default clocking cb @(posedge CLK_SYS);
   endclocking
   default disable iff (!RST_N);
   sequence s_stop_req;
      stop_rq;
   endsequence
   sequence s_stop_pulse;
      SERIAL_MEM_STOP ##1 !SERIAL_MEM_STOP;
   endsequence
   AST_STOP_PULSE: assert property (
      s_stop_req |=> s_stop_pulse)
      else $error("memory stop pulse missing or too long");
   AST_STOP_CAUSE: assert property (
      SERIAL_MEM_STOP |-> $past(stop_rq))
      else $error("memory stop pulse without a write");
   AST_PHASE: assert property (
      ctl_wr |=> PHASE_DELAY_CH2 == ctl_reg[23:16])
      else $error("phase delay differs from written value");
   AST_RANGE: assert property (
      {CUR2_RANGE_SELECT, CUR1_RANGE_SELECT} ==
      {ctl_reg[CTRL_CUR2_RANGE], ctl_reg[CTRL_CUR1_RANGE]})
      else $error("range selects differ from control word");
   AST_DISABLE: assert property (
      {HOST_CLOCK_OUT_DISABLE, CRYSTAL_OSC_DISABLE} == ctl_reg[2:1])
      else $error("clock disables differ from control word");
   AST_IRQ_IDLE: assert property (
      msk_reg == 24'h000000 |=> IRQ_OUT != $past(IRQ_POLARITY_SELECT))
      else $error("interrupt active with all sources masked");
   AST_IRQ_OE: assert property (
      $stable(od_w) |-> IRQ_OE == !(od_w && IRQ_OUT))
      else $error("interrupt output enable wrong for drive mode");
   AST_PULSE_SRC: assert property (
      LOWRATE_STB |=> PULSE_SRC == $past(PULSE_IN))
      else $error("pulse sources not loaded at interval end");
   AST_PULSE_HOLD: assert property (
      !LOWRATE_STB |=> $stable(PULSE_SRC))
      else $error("pulse sources changed inside interval");
   AST_IRQ_PULSE: assert property (
      hi_puls && $past(hi_puls) && IRQ_OUT |=> !IRQ_OUT)
      else $error("interrupt pulse longer than one cycle");
endmodule
bind mrscr_regs mrscr_regs_checker mrscr_regs_checker_i (.*);
`default_nettype wire

// file: testbench/mrscr_host.sv
`timescale 1ns/1ps
`default_nettype none
module mrscr_host (
   input  wire logic        CLK_SYS,
   output logic             REG_SEL,
   output logic [4:0]       REG_ADDR,
   output logic             REG_WR,
   output logic             REG_RD,
   output logic [23:0]      REG_WDATA,
   input  wire logic [23:0] REG_RDATA
);
   // ====================
   // One word access; idle address and data show inverted values.
   initial begin
      REG_SEL = 1'b0;
      REG_WR = 1'b0;
      REG_RD = 1'b0;
      REG_ADDR = 5'h00;
      REG_WDATA = 24'h000000;
   end
   task automatic acc(input logic w, input logic [4:0] a,
                      input logic [23:0] d, output logic [23:0] q);
      @(posedge CLK_SYS);
      #1;
      REG_SEL = 1'b1;
      REG_WR = w;
      REG_RD = !w;
      REG_ADDR = a;
      REG_WDATA = d;
      @(posedge CLK_SYS);
      #1;
      REG_SEL = 1'b0;
      REG_WR = 1'b0;
      REG_RD = 1'b0;
      REG_ADDR = ~a;
      REG_WDATA = ~d;
      q = REG_RDATA;
   endtask
endmodule
`default_nettype wire

// file: testbench/mrscr_regs_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module mrscr_regs_tb_top;
   import mrscr_pkg::*;
   logic         CLK_SYS = 1'b0;
   logic         RST_N, REG_SEL, REG_WR, REG_RD;
   logic [4:0]   REG_ADDR;
   logic [23:0]  REG_WDATA, REG_RDATA, P1_AVG, P2_AVG, TEMP_IN;
   logic [23:0]  STATUS_COND, q, b;
   logic         SAMPLE_STB, LOWRATE_STB, TEMP_STB, FREQ_STB, CMD_DONE;
   logic         BAD_CMD, SUPPLY_BELOW_LOW, SUPPLY_ABOVE_HIGH;
   logic         IRQ_PULSE_SELECT, IRQ_POLARITY_SELECT, SERIAL_MEM_STOP;
   logic         CUR1_RANGE_SELECT, CUR2_RANGE_SELECT, IRQ_OUT, IRQ_OE;
   logic         HOST_CLOCK_OUT_DISABLE, CRYSTAL_OSC_DISABLE;
   logic [7:0]   PHASE_DELAY_CH2;
   mrscr_quad_s  SAMPLES, RMS;
   mrscr_pulse_s PULSE_IN, PULSE_SRC;
   mrscr_quad_s  sq [3];
   logic [23:0]  sexp [5];
   logic [23:0]  pexp [14];
   int           err_count = 0;
   int           n_tests = 0;
   mrscr_regs mrscr_regs_i (.*);
   mrscr_host mrscr_host_i (.*);
   always #25 CLK_SYS = ~CLK_SYS;
   // ====================
   // Access and comparison tasks.
   task automatic tick;
      @(posedge CLK_SYS);
      #1;
   endtask
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [4:0] a, input logic [23:0] d);
      mrscr_host_i.acc(1'b1, a, d, q);
   endtask
   task automatic rc(input logic [4:0] a, input logic [23:0] e);
      mrscr_host_i.acc(1'b0, a, 24'h000000, q);
      chk(q, e);
   endtask
   task automatic summarize;
      $display("comparisons=%0d mismatches=%0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge CLK_SYS);
      err_count++;
      summarize();
   end
   // ====================
   // Test sequence.
   initial begin
      RST_N = 1'b0;
      {SAMPLE_STB, LOWRATE_STB, TEMP_STB, FREQ_STB, CMD_DONE} = 5'h00;
      {BAD_CMD, SUPPLY_BELOW_LOW, SUPPLY_ABOVE_HIGH} = 3'h0;
      {IRQ_PULSE_SELECT, IRQ_POLARITY_SELECT} = 2'h0;
      STATUS_COND = 24'h000000;
      SAMPLES = {4{24'h000000}};
      RMS = '{24'h800000, 24'h800000, 24'h800000, 24'h400000};
      P1_AVG = 24'h100000;
      P2_AVG = 24'hF80000;
      TEMP_IN = 24'h123456;
      PULSE_IN = '{24'h654321, 24'h0ABCDE, 24'hF00001};
      sq[0] = '{24'h200000, 24'h100000, 24'h300000, 24'h400000};
      sq[1] = '{24'hA00000, 24'hF00000, 24'h010000, 24'h800000};
      sq[2] = '{24'h100000, 24'h700000, 24'hF00000, 24'h7FFFFF};
      sexp = '{24'h800001, 24'h100001, 24'h000081, 24'h000003, 24'h800001};
      pexp = '{24'hA00000, 24'h700000, 24'h200000, 24'h400000,
               24'h300000, 24'h800000, 24'h100000, 24'hC00000,
               24'h000000, 24'h123456, 24'h000000, 24'h654321,
               24'h0ABCDE, 24'hF00001};
      repeat (16) @(posedge CLK_SYS);
      #1;
      RST_N = 1'b1;
      tick();
      rc(ADDR_STATUS, 24'h800001);
      rc(ADDR_MASK, 24'h000000);
      rc(ADDR_CTRL, 24'h000000);
      wr(5'h10, 24'hFFFFFF);
      rc(5'h10, 24'h000000);
      wr(ADDR_STATUS, 24'h000000);
      rc(ADDR_STATUS, 24'h800001);
      wr(ADDR_STATUS, 24'h800000);
      rc(ADDR_STATUS, 24'h000001);
      for (int i = 1; i < 23; i++) begin
         if (COND_BITS[i]) begin
            b = 24'h000001 << i;
            STATUS_COND = b;
            wr(ADDR_STATUS, b);
            rc(ADDR_STATUS, b | 24'h000001);
            STATUS_COND = 24'h000000;
            wr(ADDR_STATUS, b);
            rc(ADDR_STATUS, 24'h000001);
         end
      end
      for (int k = 0; k < 5; k++) begin
         {CMD_DONE, FREQ_STB, TEMP_STB, SAMPLE_STB, LOWRATE_STB} = 5'h01 << k;
         tick();
         {CMD_DONE, FREQ_STB, TEMP_STB, SAMPLE_STB, LOWRATE_STB} = 5'h00;
         rc(ADDR_STATUS, sexp[k]);
         wr(ADDR_STATUS, 24'hFFFFFE);
      end
      BAD_CMD = 1'b1;
      tick();
      BAD_CMD = 1'b0;
      rc(ADDR_STATUS, 24'h000000);
      wr(ADDR_STATUS, 24'h000001);
      rc(ADDR_STATUS, 24'h000001);
      SUPPLY_BELOW_LOW = 1'b1;
      tick();
      SUPPLY_BELOW_LOW = 1'b0;
      wr(ADDR_STATUS, 24'h000004);
      rc(ADDR_STATUS, 24'h000005);
      SUPPLY_ABOVE_HIGH = 1'b1;
      wr(ADDR_STATUS, 24'h000004);
      rc(ADDR_STATUS, 24'h000001);
      SUPPLY_ABOVE_HIGH = 1'b0;
      STATUS_COND = 24'h020000;
      for (int m = 0; m < 8; m++) begin
         {IRQ_PULSE_SELECT, IRQ_POLARITY_SELECT} = m[1:0];
         wr(ADDR_CTRL, {19'h00000, m[2], 4'h0});
         wr(ADDR_MASK, 24'h020000);
         rc(ADDR_MASK, 24'h020000);
         chk({23'h000000, IRQ_OUT}, {23'h000000, m[0] ^ m[1]});
         b = {23'h000000, !(m[2] && (m[0] ^ m[1]))};
         chk({23'h000000, IRQ_OE}, b);
         wr(ADDR_MASK, 24'h000000);
         tick();
         chk({23'h000000, IRQ_OUT}, {23'h000000, !m[0]});
      end
      STATUS_COND = 24'h000000;
      wr(ADDR_STATUS, 24'hFFFFFE);
      wr(ADDR_CTRL, 24'hFFFFFF);
      chk({23'h000000, SERIAL_MEM_STOP}, 24'h000001);
      rc(ADDR_CTRL, 24'hFF1036);
      chk({8'h00, PHASE_DELAY_CH2, 4'h0, CUR2_RANGE_SELECT, CUR1_RANGE_SELECT,
        HOST_CLOCK_OUT_DISABLE, CRYSTAL_OSC_DISABLE}, 24'h00FF0F);
      chk({23'h000000, SERIAL_MEM_STOP}, 24'h000000);
      wr(ADDR_CTRL, 24'h000000);
      for (int s = 0; s < 3; s++) begin
         SAMPLES = sq[s];
         SAMPLE_STB = 1'b1;
         LOWRATE_STB = (s == 2);
         tick();
      end
      SAMPLE_STB = 1'b0;
      LOWRATE_STB = 1'b0;
      wr(ADDR_S1, 24'hFFFFFF);
      repeat (60) tick();
      for (int a = 0; a < 14; a++) begin
         rc(5'h12+a[4:0], pexp[a]);
      end
      chk(PULSE_SRC.reactive, 24'hF00001);
      summarize();
   end
endmodule
`default_nettype wire
